/* ubcff_chk_sva.sv */
// checker for the usart clock and frame block: bus handshakes and line timing
// assumes: bound into ubcff_top; one aclk domain, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module ubcff_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic txd,
    input wire logic xck_out,
    input wire logic xck_oe_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
////////////////////////////////////////
    property p_rst_idle;
        $rose(aresetn) |-> txd && xck_oe_n;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("line not idle after reset");
    // shortest bit is two cycles: sync master at divisor zero
    property p_start_len;
        $fell(txd) |=> !txd;
    endproperty
    a_start_len: assert property (p_start_len) else $error("low bit too short");
    property p_high_len;
        $rose(txd) |=> txd;
    endproperty
    a_high_len: assert property (p_high_len) else $error("high bit too short");
    property p_master_edge;
        !xck_oe_n && !$past(xck_oe_n) && txd != $past(txd)
            |-> xck_out != $past(xck_out) || $past(xck_out) != $past(xck_out, 2);
    endproperty
    a_master_edge: assert property (p_master_edge) else $error("txd moved off clock edge");
    property p_b_after;
        // write executes the cycle after both are held, response one later
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after) else $error("no write response");
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_block: assert property (p_b_block) else $error("write taken during response");
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write response not released");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late or wide");
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read answer not released");
    property p_r_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_block: assert property (p_r_block) else $error("read taken during answer");
    c_frame: cover property ($fell(txd));
    c_master: cover property (!xck_oe_n && $changed(xck_out));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // ubcff_chk
bind ubcff_top ubcff_chk u_chk (.*);
`default_nettype wire

/* ubcff_defines.vh */
// register map, field positions and fixed codes for the usart clock and frame block
// assumes: included by the block source by bare name; definitions only
`ifndef UBCFF_DEFINES_VH
`define UBCFF_DEFINES_VH
`define UBCFF_OFF_DATA 8'h00
`define UBCFF_OFF_CSA 8'h04
`define UBCFF_OFF_CSB 8'h08
`define UBCFF_OFF_CSC 8'h0c
`define UBCFF_OFF_BRL 8'h10
`define UBCFF_CSA_RXC 7
`define UBCFF_CSA_TXC 6
`define UBCFF_CSA_TXE 5
`define UBCFF_CSA_FE 4
`define UBCFF_CSA_PE 2
`define UBCFF_CSA_U2X 1
`define UBCFF_CSB_DIR 5
`define UBCFF_CSB_RXEN 4
`define UBCFF_CSB_TXEN 3
`define UBCFF_CSB_SZ2 2
`define UBCFF_CSB_RX8 1
`define UBCFF_CSB_TX8 0
`define UBCFF_CSC_SEL 7
`define UBCFF_CSC_SYNC 6
`define UBCFF_CSC_PMH 5
`define UBCFF_CSC_PML 4
`define UBCFF_CSC_STOP 3
`define UBCFF_CSC_SZ1 2
`define UBCFF_CSC_SZ0 1
`define UBCFF_CSC_POL 0
`define UBCFF_CSC_RST 7'h03
`define UBCFF_RESP_OK 2'b00
`define UBCFF_RESP_ERR 2'b10
`define UBCFF_PH_NORM 4'hf
`define UBCFF_PH_DBL 4'h7
`define UBCFF_SZ_NINE 3'h7
`define UBCFF_SZ_BASE 4'h5
`define UBCFF_NB_NINE 4'h9
`define UBCFF_FRAME_W 13
`endif

/* ubcff_peer.sv */
// serial peer: decodes frames on txd, sends frames on rxd
// assumes: bench sets bit_cyc and format fields before each mode
`timescale 1ns/10ps
`default_nettype none
module ubcff_peer (
    input wire logic aclk,
    input wire logic txd,
    output logic rxd
);
    int bit_cyc = 32;
    int nb = 8;
    int pen = 0;
    int two = 0;
    int got_q[$];
    initial rxd = 1'b1;
////////////////////////////////////////
    // bit 0 start, then data, parity, stops; no wait after last stop catches back-to-back
    always begin
        int w, i;
        @(negedge txd);
        w = 0;
        repeat (bit_cyc / 2) @(posedge aclk);
        for (i = 0; i < nb + pen + 2 + two; i++) begin
            w[i] = txd;
            if (i < nb + pen + 1 + two) repeat (bit_cyc) @(posedge aclk);
        end
        got_q.push_back(w);
    end
    task automatic hold(input logic v, input int n);
        rxd <= v;
        repeat (n) @(posedge aclk);
    endtask
    task automatic send(input int d, input int n, input int pe, input int od, input int tw,
                        input int bad);
        int i, p;
        p = od;
        @(posedge aclk);
        hold(1'b0, bit_cyc);
        for (i = 0; i < n; i++) begin
            hold(d[i], bit_cyc);
            p ^= d[i];
        end
        if (pe) hold(p[0], bit_cyc);
        // broken stop low for 3/4 bit: past the late mid sample at 8 samples a bit,
        // and the short low tail after it is dropped as a false start
        if (bad) hold(1'b0, bit_cyc * 3 / 4);
        hold(1'b1, bad ? bit_cyc - bit_cyc * 3 / 4 : bit_cyc);
        if (tw) hold(1'b1, bit_cyc);
    endtask
endmodule // ubcff_peer
`default_nettype wire

/* ubcff_top.v */
// usart baud generator, clock mode selection, frame transmitter and receiver
// assumes: single aclk, axi4-lite master, rxd and xck_in asynchronous to aclk
//
// Overview of operation
// - divisor counter reloads at zero and on low write
// - one generator pulse per counter zero
// - transmitter divides by 16, 8 or 2
// - receiver uses 2, 8 or 16 states
// - divisor is twelve bits, 0 to 4095
// - double speed only affects asynchronous mode
// - double speed receiver uses 8 samples
// - slave clock synchronised then edge detected
// - sync mode: clock pin input or output
// - sample on edge opposite to change edge
// - polarity picks change and sample edges
// - 5-9 data, parity option, 1-2 stops
// - start, data lsb first, parity, stops
// - start low, stop bits high
// - next frame at once or idle high
// - one shared format for both directions
// - only first stop checked for frame error
// - parity is xor of data, odd inverts
// - select bit routes shared-address writes
// - clock direction picks master or slave
// - size code seven means nine data bits
// - parity inserted only when upper bit set
`timescale 1ns/10ps
`default_nettype none
`include "ubcff_defines.vh"
module ubcff_top (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg txd,
    input wire rxd,
    input wire xck_in,
    output reg xck_out,
    output wire xck_oe_n
);

localparam TX_IDLE = 2'b01;
localparam TX_BUSY = 2'b10;
localparam RX_IDLE = 2'b01;
localparam RX_BUSY = 2'b10;
// data bits per character from the size code
function [3:0] data_bits;
    input [2:0] sz;
    data_bits = (sz == `UBCFF_SZ_NINE) ? `UBCFF_NB_NINE
                                       : `UBCFF_SZ_BASE + {2'b00, sz[1:0]};
endfunction
function parity_of;
    input [8:0] d;
    input [3:0] nb;
    input odd;
    parity_of = odd ^ (^(d & ~({9{1'b1}} << nb)));
endfunction
// frame bits in send order; unused tail stays high so stops come free
function [`UBCFF_FRAME_W-1:0] build_frame;
    input [8:0] d;
    input [3:0] nb;
    input pen;
    input odd;
    begin
        build_frame = {{(`UBCFF_FRAME_W-10){1'b1}}, d | ({9{1'b1}} << nb), 1'b0};
        if (pen) build_frame[nb+1] = parity_of(d, nb, odd);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] tx_buf;
reg tx_full;
reg [8:0] rx_data;
reg rx_complete_flag;
reg tx_complete_flag;
reg frame_error;
reg parity_error;
reg double_speed;
reg xfer_clock_direction;
reg rx_en;
reg tx_en;
reg tx_bit8;
reg [6:0] control_status_c;
reg [3:0] baud_divisor_high;
reg [7:0] baud_divisor_low;
reg [7:0] aw_addr;
reg aw_got;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_got;
reg rx_tx_sz2;
// one shared format for transmitter and receiver
wire [2:0] char_size = {rx_tx_sz2, control_status_c[`UBCFF_CSC_SZ1:`UBCFF_CSC_SZ0]};
wire [1:0] parity_mode = control_status_c[`UBCFF_CSC_PMH:`UBCFF_CSC_PML];
wire stop_bit_select = control_status_c[`UBCFF_CSC_STOP];
wire sync_mode_select = control_status_c[`UBCFF_CSC_SYNC];
wire clock_polarity = control_status_c[`UBCFF_CSC_POL];
wire [11:0] baud_divisor = {baud_divisor_high, baud_divisor_low};
wire [3:0] nbits = data_bits(char_size);
wire par_en = parity_mode[1];

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave
assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
assign s_axi_wready = ~w_got & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;
wire wr_go = aw_got & w_got;
wire wr_en = wr_go & w_strb[0];
wire rd_go = s_axi_arvalid & s_axi_arready;
wire wr_data_reg = wr_en & (aw_addr == `UBCFF_OFF_DATA);
wire wr_csa = wr_en & (aw_addr == `UBCFF_OFF_CSA);
wire wr_csb = wr_en & (aw_addr == `UBCFF_OFF_CSB);
wire wr_shared = wr_en & (aw_addr == `UBCFF_OFF_CSC);
wire wr_brl = wr_en & (aw_addr == `UBCFF_OFF_BRL);
wire rd_data_reg = rd_go & (s_axi_araddr == `UBCFF_OFF_DATA);

function mapped;
    input [7:0] a;
    begin
        mapped = (a == `UBCFF_OFF_DATA) | (a == `UBCFF_OFF_CSA) | (a == `UBCFF_OFF_CSB) |
                 (a == `UBCFF_OFF_CSC) | (a == `UBCFF_OFF_BRL);
    end
endfunction

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        aw_addr <= 8'h00;
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `UBCFF_RESP_OK;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (wr_go) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr) ? `UBCFF_RESP_OK : `UBCFF_RESP_ERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `UBCFF_RESP_OK;
    end else if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? `UBCFF_RESP_OK : `UBCFF_RESP_ERR;
        case (s_axi_araddr)
            `UBCFF_OFF_DATA: s_axi_rdata <= {24'h000000, rx_data[7:0]};
            `UBCFF_OFF_CSA: s_axi_rdata <= {24'h000000, rx_complete_flag, tx_complete_flag,
                                            ~tx_full, frame_error, 1'b0, parity_error,
                                            double_speed, 1'b0};
            `UBCFF_OFF_CSB: s_axi_rdata <= {24'h000000, 2'b00, xfer_clock_direction, rx_en,
                                            tx_en, rx_tx_sz2, rx_data[8], tx_bit8};
            // shared address reads back the frame control byte
            `UBCFF_OFF_CSC: s_axi_rdata <= {24'h000000, 1'b1, control_status_c};
            `UBCFF_OFF_BRL: s_axi_rdata <= {24'h000000, baud_divisor_low};
            default: s_axi_rdata <= 32'h0000_0000;
        endcase
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// baud generator and clock modes
reg [11:0] baud_cnt;
reg rxd_meta, rxd_s, xck_meta, xck_s, xck_prev;
wire baud_tick = (baud_cnt == 12'h000);
wire master = sync_mode_select & xfer_clock_direction;
assign xck_oe_n = ~master;
wire [3:0] ph_lim = (double_speed & ~sync_mode_select) ? `UBCFF_PH_DBL : `UBCFF_PH_NORM;
wire [3:0] ph_mid = {1'b0, ph_lim[3:1]};
// master toggles the pin on each tick, so a pin period is two ticks
wire xck_rise = master ? (baud_tick & ~xck_out) : (xck_s & ~xck_prev);
wire xck_fall = master ? (baud_tick & xck_out) : (~xck_s & xck_prev);
wire chg_edge = clock_polarity ? xck_fall : xck_rise;
wire samp_edge = clock_polarity ? xck_rise : xck_fall;

always @(posedge aclk) begin
    if (!aresetn) begin
        baud_cnt <= 12'h000;
        rxd_meta <= 1'b1;
        rxd_s <= 1'b1;
        xck_meta <= 1'b0;
        xck_s <= 1'b0;
        xck_prev <= 1'b0;
        xck_out <= 1'b0;
    end else begin
        baud_cnt <= wr_brl ? {baud_divisor_high, w_data[7:0]} :
                    baud_tick ? baud_divisor : baud_cnt - 12'h001;
        rxd_meta <= rxd;
        rxd_s <= rxd_meta;
        xck_meta <= xck_in;
        xck_s <= xck_meta;
        xck_prev <= xck_s;
        if (!master) begin
            xck_out <= clock_polarity;
        end else if (baud_tick) begin
            xck_out <= ~xck_out;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// transmitter
reg [1:0] tx_state;
reg [3:0] tx_ph;
reg [`UBCFF_FRAME_W-1:0] tx_shift;
reg [3:0] tx_left;
wire tx_ph_end = baud_tick & (tx_ph == ph_lim);
wire tx_edge = sync_mode_select ? chg_edge : tx_ph_end;
wire [`UBCFF_FRAME_W-1:0] next_frame =
    build_frame({tx_bit8, tx_buf}, nbits, par_en, parity_mode[0]);
wire [3:0] frame_len = nbits + {3'b000, par_en} + {3'b000, stop_bit_select} + 4'h1;
wire tx_load = tx_edge & tx_full & tx_en & ~(tx_state == TX_BUSY && tx_left != 4'h0);
wire tx_finish = tx_edge & (tx_state == TX_BUSY) & (tx_left == 4'h0) & ~tx_load;

always @(posedge aclk) begin
    if (!aresetn) begin
        tx_state <= TX_IDLE;
        tx_ph <= 4'h0;
        tx_shift <= {`UBCFF_FRAME_W{1'b1}};
        tx_left <= 4'h0;
        txd <= 1'b1;
        tx_full <= 1'b0;
        tx_buf <= 8'h00;
    end else begin
        tx_ph <= baud_tick ? ((tx_ph >= ph_lim) ? 4'h0 : tx_ph + 4'h1) : tx_ph;
        tx_buf <= wr_data_reg ? w_data[7:0] : tx_buf;
        tx_full <= wr_data_reg | (tx_full & ~tx_load);
        case (tx_state)
            TX_IDLE: begin
                if (tx_load) begin
                    txd <= next_frame[0];
                    tx_shift <= next_frame >> 1;
                    tx_left <= frame_len;
                    tx_state <= TX_BUSY;
                end
            end
            TX_BUSY: begin
                if (tx_edge && tx_left != 4'h0) begin
                    txd <= tx_shift[0];
                    tx_shift <= {1'b1, tx_shift[`UBCFF_FRAME_W-1:1]};
                    tx_left <= tx_left - 4'h1;
                end else if (tx_load) begin
                    txd <= next_frame[0];
                    tx_shift <= next_frame >> 1;
                    tx_left <= frame_len;
                end else if (tx_finish) begin
                    txd <= 1'b1;
                    tx_state <= TX_IDLE;
                end
            end
            default: tx_state <= TX_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// receiver
reg [1:0] rx_state;
reg [3:0] rx_ph;
reg [3:0] rx_idx;
reg [8:0] rx_sh;
reg rx_par;
wire [3:0] stop_idx = nbits + {3'b000, par_en} + 4'h1;
// async: 16 or 8 state recovery per bit; sync: two states, one per pin edge
wire rx_take = sync_mode_select ? samp_edge : (baud_tick & (rx_ph == ph_mid));
wire rx_start_sync = sync_mode_select & samp_edge & ~rxd_s;
wire rx_start_async = ~sync_mode_select & baud_tick & ~rxd_s;
wire rx_done = (rx_state == RX_BUSY) & rx_take & (rx_idx == stop_idx);
wire [8:0] rx_word = rx_sh;
wire rx_perr = par_en & (rx_par != parity_of(rx_word, nbits, parity_mode[0]));

always @(posedge aclk) begin
    if (!aresetn) begin
        rx_state <= RX_IDLE;
        rx_ph <= 4'h0;
        rx_idx <= 4'h0;
        rx_sh <= 9'h000;
        rx_par <= 1'b0;
        rx_data <= 9'h000;
        frame_error <= 1'b0;
        parity_error <= 1'b0;
    end else begin
        case (rx_state)
            RX_IDLE: begin
                if (rx_en && (rx_start_sync || rx_start_async)) begin
                    rx_state <= RX_BUSY;
                    rx_ph <= 4'h0;
                    rx_idx <= sync_mode_select ? 4'h1 : 4'h0;
                    rx_sh <= 9'h000;
                end
            end
            RX_BUSY: begin
                rx_ph <= baud_tick ? ((rx_ph >= ph_lim) ? 4'h0 : rx_ph + 4'h1) : rx_ph;
                if (rx_take) begin
                    rx_idx <= rx_idx + 4'h1;
                    if (rx_idx == 4'h0 && rxd_s) begin
                        rx_state <= RX_IDLE; // false start
                    end else if (rx_idx != 4'h0 && rx_idx <= nbits) begin
                        rx_sh[rx_idx-4'h1] <= rxd_s;
                    end else if (rx_idx != stop_idx) begin
                        rx_par <= rxd_s;
                    end
                    if (rx_done) begin
                        // second stop is never looked at
                        rx_data <= rx_word;
                        frame_error <= ~rxd_s;
                        parity_error <= rx_perr;
                        rx_state <= RX_IDLE;
                    end
                end
                if (!rx_en) begin
                    rx_state <= RX_IDLE;
                end
            end
            default: rx_state <= RX_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// control bits and flags; hardware set wins over software clear
always @(posedge aclk) begin
    if (!aresetn) begin
        rx_complete_flag <= 1'b0;
        tx_complete_flag <= 1'b0;
        double_speed <= 1'b0;
        xfer_clock_direction <= 1'b0;
        rx_en <= 1'b0;
        tx_en <= 1'b0;
        tx_bit8 <= 1'b0;
        rx_tx_sz2 <= 1'b0;
        control_status_c <= `UBCFF_CSC_RST;
        baud_divisor_high <= 4'h0;
        baud_divisor_low <= 8'h00;
    end else begin
        rx_complete_flag <= rx_done | (rx_complete_flag & ~rd_data_reg);
        tx_complete_flag <= tx_finish |
                            (tx_complete_flag & ~(wr_csa & w_data[`UBCFF_CSA_TXC]));
        double_speed <= wr_csa ? w_data[`UBCFF_CSA_U2X] : double_speed;
        if (wr_csb) begin
            xfer_clock_direction <= w_data[`UBCFF_CSB_DIR];
            rx_en <= w_data[`UBCFF_CSB_RXEN];
            tx_en <= w_data[`UBCFF_CSB_TXEN];
            rx_tx_sz2 <= w_data[`UBCFF_CSB_SZ2];
            tx_bit8 <= w_data[`UBCFF_CSB_TX8];
        end
        if (wr_shared && w_data[`UBCFF_CSC_SEL]) begin
            control_status_c <= w_data[6:0];
        end else if (wr_shared) begin
            baud_divisor_high <= w_data[3:0];
        end
        baud_divisor_low <= wr_brl ? w_data[7:0] : baud_divisor_low;
    end
end

endmodule // ubcff_top
`default_nettype wire

/* usart_baud_clock_and_frame_format_test.sv */
// testbench for the usart clock and frame block against a serial peer model
// assumes: ubcff_top, ubcff_peer and the bound checker compiled alongside
`timescale 1ns/10ps
`default_nettype none
module usart_baud_clock_and_frame_format_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic xck_in = 1'b0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic txd, rxd, xck_out, xck_oe_n;
    int errors = 0;
    int n_tests = 0;
    int xc = 0;
    bit slave_on = 1'b0;
    logic [31:0] rv;
    logic [1:0] rr;
    int q[$];
    ubcff_top dut (.*);
    ubcff_peer peer (.*);
    always #12.5 aclk = ~aclk;
    // slave clock of 12 cycles a period, well under a quarter of aclk
    always @(posedge aclk) begin
        xc <= (xc == 5) ? 0 : xc + 1;
        if (slave_on && xc == 5) xck_in <= ~xck_in;
    end
////////////////////////////////////////
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task to;
        errors++;
        $display("[ERR] wait expected done seen timeout");
        stop_test();
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (++n > 200) to();
        end while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (++n > 200) to();
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task poll(input logic [7:0] a, input int b);
        int n;
        n = 0;
        do begin
            rd(a);
            if (++n > 2000) to();
        end while (rv[b] !== 1'b1);
    endtask
    // any window of k*(div+1) cycles holds exactly k ticks, whatever the phase
    task tog(input int cyc, input int exp);
        int c, i;
        logic last;
        c = 0;
        last = xck_out;
        for (i = 0; i < cyc; i++) begin
            @(posedge aclk);
            if (xck_out !== last) c++;
            last = xck_out;
        end
        chk("xck toggles", exp, c);
    endtask
    function automatic int fw(int d, int n, int pe, int od, int tw);
        int w, p, i;
        w = 0;
        p = od;
        for (i = 0; i < n; i++) begin
            w[i+1] = d[i];
            p ^= d[i];
        end
        if (pe) w[n+1] = p[0];
        w[n+1+pe] = 1'b1;
        if (tw) w[n+2+pe] = 1'b1;
        return w;
    endfunction
////////////////////////////////////////
    initial begin
        int m, k, d9, dv, sz, nb, pe, od, tw, bad, n, mask;
        void'($urandom(32'hd24f));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h40);
        chk("unmapped read resp", 32'h2, rr);
        wr(8'h44, 32'h0);
        chk("unmapped write resp", 32'h2, rr);
        rd(8'h08);
        chk("control_status_b reset", 32'h0, rv);
        // modes: async normal, async double, sync master, sync slave
        for (m = 0; m < 4; m++) begin
            dv = m < 2 ? 1 : 3;
            sz = $urandom_range(4);
            if (sz == 4) sz = 7;
            nb = sz == 7 ? 9 : sz + 5;
            mask = (1 << nb) - 1;
            pe = $urandom_range(1);
            od = pe ? $urandom_range(1) : 0;
            tw = $urandom_range(1);
            peer.bit_cyc = m == 0 ? 16 * (dv + 1) : m == 1 ? 8 * (dv + 1) :
                           m == 2 ? 2 * (dv + 1) : 12;
            peer.nb = nb;
            peer.pen = pe;
            peer.two = tw;
            slave_on = m == 3;
            // earlier frames must be out before the format changes
            if (m > 0) poll(8'h04, 6);
            wr(8'h08, 32'h0);
            wr(8'h0c, dv >> 8);
            wr(8'h10, dv & 255);
            wr(8'h04, 64 | (m == 1) << 1);
            wr(8'h0c, 8'h80 | (m > 1) << 6 | pe << 5 | od << 4 | tw << 3 | (sz & 3) << 1
                      | (m == 3));
            for (k = 0; k < 3; k++) begin
                d9 = $urandom_range(511);
                poll(8'h04, 5);
                wr(8'h08, (m == 2) << 5 | 24 | (sz >> 2) << 2 | d9 >> 8);
                wr(8'h00, d9 & 255);
                q.push_back(fw(d9 & mask, nb, pe, od, tw));
            end
            n = 0;
            while (peer.got_q.size() < 3) begin
                @(posedge aclk);
                if (++n > 20000) to();
            end
            while (q.size() > 0) chk("tx frame", q.pop_front(),
                                     peer.got_q.pop_front());
            chk("xck enable", m != 2, xck_oe_n);
            if (m == 2) begin
                tog(8 * (dv + 1), 8);
                wr(8'h0c, 32'h1);
                wr(8'h10, 32'h0);
                tog(2 * 257, 2);
            end
            for (k = 0; k < 3 && m < 2; k++) begin
                d9 = $urandom_range(511);
                bad = $urandom_range(1);
                peer.send(d9, nb, pe, od, tw, bad);
                poll(8'h04, 7);
                chk("frame error", bad, rv[4]);
                chk("parity error", 32'h0, rv[2]);
                rd(8'h08);
                if (nb == 9) chk("ninth bit", d9 >> 8, rv[1]);
                rd(8'h00);
                chk("rx data", d9 & mask & 255, rv);
            end
        end
        stop_test();
    end
endmodule // usart_baud_clock_and_frame_format_test
`default_nettype wire
